// file: logic/acc_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Start bit written one in power-down launches one conversion; else ignored.
// - Start bit reads zero while converting, one while idle.
// - Bits 14:12 select input pair, default 000.
// - Bits 11:9 select full-scale gain range, default 010.
// - Bit 8: zero continuous, one single-shot (default).
// - Bits 7:5 select rate, default 100.
// - Comparator type: zero traditional hysteresis, one window.
// - Polarity: zero active-low alert, one active-high.
// - Non-latching alert releases when results return within limits; traditional mode here releases only below the lower limit.
// - Latched alert holds until result read or alert response won.
// - Queue 11 disables comparator, pin driven high; ready use here overrides it and still drives the pin as ready indicator.
// - Queue 00/01/10 assert after one/two/four successive exceedances.
// - Limits are 16-bit twos complement, compared digitally with results.
// - Low four limit bits ignored in comparison.
// - Upper MSB one and lower MSB zero selects ready-indicator use.
// - Ready use: follow status in single-shot, pulse per conversion continuous.
// - Pointer low bits select result, control, lower, upper.
// - Result holds 12-bit code in 15:4, low bits zero, cleared at reset.
module acc_regs
  import acc_pkg::*;
(
  input wire logic mclk_in, // System clock
  input wire logic sys_rst_in, // Async reset, active high
  input wire acc_pkg::acc_req_t req_in, // Register access strobe
  input wire logic [1:0] rd_ptr_in, // Pointer for read data
  output logic [15:0] rd_data_out, // Register read data
  input wire acc_pkg::acc_conv_t conv_in, // Conversion finished
  input wire logic alert_resp_won_in, // Alert response won pulse
  output logic conv_start_out, // Launch one conversion
  output logic converting_out, // Conversion in progress
  output logic [2:0] input_pair_select_out, // Input pair
  output logic [2:0] gain_range_select_out, // Gain range
  output logic continuous_out, // Continuous mode
  output logic [2:0] rate_select_out, // Rate code
  output logic alert_pin_out // Alert/ready pin level
);
  import acc_pkg::*;

  acc_ctrl_t ctrl_q;
  logic [15:0] lower_q;
  logic [15:0] upper_q;
  logic [15:0] result_q;
  logic busy_q;
  logic start_q;
  logic alert_q;
  logic [2:0] hits_q;
  logic rdy_pulse_q;
  logic hyst_q;

  logic wr_ctrl;
  logic powered_down;
  logic signed [11:0] res_s;
  logic signed [11:0] up_s;
  logic signed [11:0] lo_s;
  logic above;
  logic below;
  logic outside;
  logic ready_use;
  logic alert_active;

  // Successive exceedance count needed per queue code
  function automatic logic [2:0] acc_queue_need(input logic [1:0] q);
    case (q)
      2'h0: acc_queue_need = 3'h1;
      2'h1: acc_queue_need = 3'h2;
      2'h2: acc_queue_need = 3'h4;
      default: acc_queue_need = 3'h7;
    endcase
  endfunction

  assign wr_ctrl = req_in.wr && (req_in.ptr == ACC_PTR_CTRL);
  // Start pulse in flight counts as busy, so a back-to-back start is refused
  assign powered_down = ctrl_q.single_shot && !busy_q && !start_q;

  // Control word; start bit written one only launches in power-down
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_q <= acc_ctrl_t'(ACC_CTRL_RST);
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= acc_ctrl_t'(req_in.wdata);
      ctrl_q.status_start_bit <= 1'b0;
    end
  end

  // Start pulse to the converter
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= wr_ctrl && req_in.wdata[ACC_START_BIT] && powered_down;
    end
  end

  // Busy tracking: single-shot busy from start to done, continuous always
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      busy_q <= 1'b0;
    end
    else if (start_q)
    begin
      busy_q <= 1'b1;
    end
    else if (conv_in.done && ctrl_q.single_shot)
    begin
      busy_q <= 1'b0;
    end
    else if (!ctrl_q.single_shot)
    begin
      busy_q <= 1'b1;
    end
  end

  // Limit registers
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      lower_q <= ACC_LOWER_RST;
      upper_q <= ACC_UPPER_RST;
    end
    else if (req_in.wr)
    begin
      if (req_in.ptr == ACC_PTR_LOWER)
      begin
        lower_q <= req_in.wdata;
      end
      if (req_in.ptr == ACC_PTR_UPPER)
      begin
        upper_q <= req_in.wdata;
      end
    end
  end

  // Conversion result, low nibble zero
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      result_q <= ACC_RESULT_RST;
    end
    else if (conv_in.done)
    begin
      result_q <= {conv_in.code, 4'h0};
    end
  end

  // Comparison on upper twelve bits only
  assign res_s = signed'(conv_in.code);
  assign up_s = signed'(upper_q[15:4]);
  assign lo_s = signed'(lower_q[15:4]);
  assign above = res_s > up_s;
  assign below = res_s < lo_s;
  assign outside = above || below;
  assign ready_use = upper_q[15] && !lower_q[15];

  // Hysteresis state of the traditional comparator
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      hyst_q <= 1'b0;
    end
    else if (conv_in.done)
    begin
      if (above)
      begin
        hyst_q <= 1'b1;
      end
      else if (below)
      begin
        hyst_q <= 1'b0;
      end
    end
  end

  // Successive exceedance queue and alert state
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      hits_q <= 3'h0;
      alert_q <= 1'b0;
    end
    else if (ctrl_q.alert_queue_depth == ACC_QUEUE_OFF || ready_use)
    begin
      hits_q <= 3'h0;
      alert_q <= 1'b0;
    end
    else if (conv_in.done)
    begin
      if ((ctrl_q.window_mode ? outside : (above || (hyst_q && !below))) )
      begin
        // Saturated count must still re-arm a latched alert cleared by a read
        if (hits_q >= acc_queue_need(ctrl_q.alert_queue_depth) - 3'h1)
        begin
          alert_q <= 1'b1;
        end
        if (hits_q != 3'h7)
        begin
          hits_q <= hits_q + 3'h1;
        end
      end
      else
      begin
        hits_q <= 3'h0;
        if (!ctrl_q.alert_latch_enable)
        begin
          alert_q <= 1'b0;
        end
      end
    end
    else if (ctrl_q.alert_latch_enable && ((req_in.rd_result) || alert_resp_won_in))
    begin
      alert_q <= 1'b0;
    end
  end

  // Ready pulse per conversion in continuous mode
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rdy_pulse_q <= 1'b0;
    end
    else
    begin
      rdy_pulse_q <= conv_in.done && !ctrl_q.single_shot;
    end
  end

  // Pin level: ready use, disabled high, else alert with polarity
  always_comb
  begin
    if (ready_use)
    begin
      alert_active = ctrl_q.single_shot ? !busy_q : rdy_pulse_q;
    end
    else
    begin
      alert_active = alert_q;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      alert_pin_out <= 1'b1;
    end
    else if (!ready_use && ctrl_q.alert_queue_depth == ACC_QUEUE_OFF)
    begin
      alert_pin_out <= 1'b1;
    end
    else
    begin
      alert_pin_out <= ctrl_q.alert_polarity ? alert_active : !alert_active;
    end
  end

  // Read mux; start bit shows idle state
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_data_out <= 16'h0000;
    end
    else
    begin
      case (rd_ptr_in)
        ACC_PTR_RESULT: rd_data_out <= result_q;
        ACC_PTR_CTRL: rd_data_out <= {!busy_q, ctrl_q[14:0]};
        ACC_PTR_LOWER: rd_data_out <= lower_q;
        ACC_PTR_UPPER: rd_data_out <= upper_q;
        default: rd_data_out <= 16'h0000;
      endcase
    end
  end

  assign conv_start_out = start_q;
  assign converting_out = busy_q;
  assign input_pair_select_out = ctrl_q.input_pair_select;
  assign gain_range_select_out = ctrl_q.gain_range_select;
  assign continuous_out = !ctrl_q.single_shot;
  assign rate_select_out = ctrl_q.rate_select;
endmodule
`default_nettype wire

// file: logic/acc_pkg.sv
`default_nettype none
package acc_pkg;
  // Register pointer codes
  localparam logic [1:0] ACC_PTR_RESULT = 2'h0;
  localparam logic [1:0] ACC_PTR_CTRL = 2'h1;
  localparam logic [1:0] ACC_PTR_LOWER = 2'h2;
  localparam logic [1:0] ACC_PTR_UPPER = 2'h3;
  // Reset values
  localparam logic [15:0] ACC_CTRL_RST = 16'h8583;
  localparam logic [15:0] ACC_LOWER_RST = 16'h8000;
  localparam logic [15:0] ACC_UPPER_RST = 16'h7fff;
  localparam logic [15:0] ACC_RESULT_RST = 16'h0000;
  // Control word field positions
  localparam int ACC_START_BIT = 15;
  localparam int ACC_MODE_BIT = 8;
  localparam int ACC_WINDOW_BIT = 4;
  localparam int ACC_POL_BIT = 3;
  localparam int ACC_LATCH_BIT = 2;
  localparam logic [1:0] ACC_QUEUE_OFF = 2'h3;
  // Ready pulse width and clock period in ns, rounded up to clocks
  localparam int ACC_RDY_PULSE_NS = 25;
  localparam int ACC_CLK_NS = 25;
  localparam int ACC_RDY_PULSE_CYC = (ACC_RDY_PULSE_NS + ACC_CLK_NS - 1) / ACC_CLK_NS;

  // Control word fields
  typedef struct packed {
    logic status_start_bit;
    logic [2:0] input_pair_select;
    logic [2:0] gain_range_select;
    logic single_shot;
    logic [2:0] rate_select;
    logic window_mode;
    logic alert_polarity;
    logic alert_latch_enable;
    logic [1:0] alert_queue_depth;
  } acc_ctrl_t;

  // Register access request from the serial bus front end
  typedef struct packed {
    logic wr;
    logic rd_result;
    logic [1:0] ptr;
    logic [15:0] wdata;
  } acc_req_t;

  // Finished conversion from the converter core
  typedef struct packed {
    logic done;
    logic [11:0] code;
  } acc_conv_t;
endpackage
`default_nettype wire

// file: bench/acc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acc_regs_sva
  import acc_pkg::*;
(
  input wire logic mclk_in, // Clock
  input wire logic sys_rst_in, // Reset
  input wire acc_pkg::acc_req_t req_in, // Request
  input wire logic [1:0] rd_ptr_in, // Pointer
  input wire logic [15:0] rd_data_out, // Read data
  input wire acc_pkg::acc_conv_t conv_in, // Result in
  input wire logic alert_resp_won_in, // Response won
  input wire logic conv_start_out, // Start
  input wire logic converting_out, // Busy
  input wire logic [2:0] input_pair_select_out, // Pair
  input wire logic [2:0] gain_range_select_out, // Gain
  input wire logic continuous_out, // Mode
  input wire logic [2:0] rate_select_out, // Rate
  input wire logic alert_pin_out // Pin
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  logic cw;
  // Control word write strobe
  assign cw = req_in.wr && req_in.ptr == ACC_PTR_CTRL;
  chk_start_once: assert property (conv_start_out |=> !conv_start_out)
    else $error("start pulse too long");
  chk_start_cause: assert property (conv_start_out |-> $past(cw && req_in.wdata[15] && !converting_out))
    else $error("start without idle start write");
  chk_busy_follow: assert property (conv_start_out |=> converting_out)
    else $error("no busy after start");
  chk_pair_field: assert property (cw |=> input_pair_select_out == $past(req_in.wdata[14:12]))
    else $error("pair field wrong");
  chk_gain_field: assert property (cw |=> gain_range_select_out == $past(req_in.wdata[11:9]))
    else $error("gain field wrong");
  chk_mode_field: assert property (cw |=> continuous_out == !$past(req_in.wdata[8]))
    else $error("mode field wrong");
  chk_rate_field: assert property (cw |=> rate_select_out == $past(req_in.wdata[7:5]))
    else $error("rate field wrong");
  chk_result_nibble: assert property ($past(rd_ptr_in) == ACC_PTR_RESULT |-> rd_data_out[3:0] == 4'h0)
    else $error("result low bits set");
  // Main scenarios
  cover property (conv_start_out);
  cover property (conv_in.done ##2 $fell(alert_pin_out));
  cover property (req_in.rd_result);
endmodule
bind acc_regs acc_regs_sva u_sva (.*);
`default_nettype wire

// file: bench/acc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_master_model
  import acc_pkg::*;
(
  input wire logic mclk_in, // Clock
  output acc_pkg::acc_req_t req_out, // Request
  output logic [1:0] rd_ptr_out, // Pointer
  input wire logic [15:0] rd_data_in // Read data
);
  // Idle bus at start
  initial
  begin
    req_out = '0;
    rd_ptr_out = ACC_PTR_CTRL;
  end
  // Whole word at one edge, then data scrambled
  task automatic wr(input logic [1:0] p, input logic [15:0] d);
    @(posedge mclk_in);
    req_out <= {1'b1, 1'b0, p, d};
    @(posedge mclk_in);
    req_out <= {1'b0, 1'b0, ~p, ~d};
  endtask
  // Both bytes always taken, no early stop
  task automatic rd(input logic [1:0] p, output logic [15:0] d);
    @(posedge mclk_in);
    rd_ptr_out <= p;
    repeat (2) @(posedge mclk_in);
    d = rd_data_in;
    req_out.rd_result <= (p == ACC_PTR_RESULT);
    @(posedge mclk_in);
    req_out.rd_result <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: bench/acc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acc_regs_tb;
  import acc_pkg::*;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  acc_req_t req_in;
  logic [1:0] rd_ptr_in;
  logic [15:0] rd_data_out;
  acc_conv_t conv_in = '0;
  logic alert_resp_won_in = 1'b0;
  logic conv_start_out, converting_out, continuous_out, alert_pin_out;
  logic [2:0] input_pair_select_out, gain_range_select_out, rate_select_out;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Clock
  initial forever #12.5 mclk_in = ~mclk_in;
  acc_master_model mst (.mclk_in(mclk_in), .req_out(req_in), .rd_ptr_out(rd_ptr_in), .rd_data_in(rd_data_out));
  acc_regs dut (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .req_in(req_in),
    .rd_ptr_in(rd_ptr_in),
    .rd_data_out(rd_data_out),
    .conv_in(conv_in),
    .alert_resp_won_in(alert_resp_won_in),
    .conv_start_out(conv_start_out),
    .converting_out(converting_out),
    .input_pair_select_out(input_pair_select_out),
    .gain_range_select_out(gain_range_select_out),
    .continuous_out(continuous_out),
    .rate_select_out(rate_select_out),
    .alert_pin_out(alert_pin_out)
  );
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic ck_rd(input logic [1:0] p, input logic [15:0] e);
    logic [15:0] v;
    mst.rd(p, v);
    chk(v, e);
  endtask
  // One result pulse, waits until the pin has settled
  task automatic done(input logic [11:0] c);
    @(posedge mclk_in);
    conv_in <= {1'b1, c};
    @(posedge mclk_in);
    conv_in <= {1'b0, ~c};
    repeat (2) @(posedge mclk_in);
    #1;
  endtask
  task automatic t_reset;
    ck_rd(ACC_PTR_CTRL, ACC_CTRL_RST);
    ck_rd(ACC_PTR_LOWER, ACC_LOWER_RST);
    ck_rd(ACC_PTR_UPPER, ACC_UPPER_RST);
    ck_rd(ACC_PTR_RESULT, 16'h0000);
    chk(alert_pin_out, 16'h0001);
    chk({input_pair_select_out, gain_range_select_out, continuous_out, rate_select_out}, 16'h0024);
  endtask
  task automatic t_fields;
    mst.wr(ACC_PTR_CTRL, 16'h3ae0);
    #1;
    chk({input_pair_select_out, gain_range_select_out, continuous_out, rate_select_out}, 16'h01df);
    ck_rd(ACC_PTR_CTRL, 16'h3ae0);
    mst.wr(ACC_PTR_CTRL, 16'h0583);
    // Conversion left running by continuous mode finishes before power-down
    done(12'h000);
    chk(converting_out, 16'h0000);
  endtask
  task automatic t_start;
    mst.wr(ACC_PTR_CTRL, 16'h0583);
    #1;
    chk(conv_start_out, 16'h0000);
    mst.wr(ACC_PTR_CTRL, 16'h8583);
    #1;
    chk(conv_start_out, 16'h0001);
    mst.wr(ACC_PTR_CTRL, 16'h8583);
    #1;
    chk(conv_start_out, 16'h0000);
    ck_rd(ACC_PTR_CTRL, 16'h0583);
    done(12'h9ab);
    chk(converting_out, 16'h0000);
    ck_rd(ACC_PTR_RESULT, 16'h9ab0);
  endtask
  task automatic t_alert;
    mst.wr(ACC_PTR_LOWER, 16'h080f);
    mst.wr(ACC_PTR_UPPER, 16'h100f);
    mst.wr(ACC_PTR_CTRL, 16'h0581);
    done(12'h200);
    chk(alert_pin_out, 16'h0001);
    done(12'h200);
    chk(alert_pin_out, 16'h0000);
    done(12'h080);
    chk(alert_pin_out, 16'h0000);
    done(12'h07f);
    chk(alert_pin_out, 16'h0001);
    mst.wr(ACC_PTR_CTRL, 16'h0582);
    repeat (3) done(12'h200);
    chk(alert_pin_out, 16'h0001);
    done(12'h200);
    chk(alert_pin_out, 16'h0000);
    done(12'h07f);
    mst.wr(ACC_PTR_CTRL, 16'h059c);
    done(12'h07f);
    chk(alert_pin_out, 16'h0001);
    done(12'h0c0);
    chk(alert_pin_out, 16'h0001);
    ck_rd(ACC_PTR_RESULT, 16'h0c00);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(alert_pin_out, 16'h0000);
    done(12'h7f0);
    chk(alert_pin_out, 16'h0001);
    @(posedge mclk_in);
    alert_resp_won_in <= 1'b1;
    @(posedge mclk_in);
    alert_resp_won_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    chk(alert_pin_out, 16'h0000);
    mst.wr(ACC_PTR_CTRL, 16'h058b);
    done(12'h7f0);
    chk(alert_pin_out, 16'h0001);
  endtask
  // Ready indicator use in single-shot and continuous mode
  task automatic t_ready;
    mst.wr(ACC_PTR_UPPER, 16'h8000);
    mst.wr(ACC_PTR_LOWER, 16'h0000);
    mst.wr(ACC_PTR_CTRL, 16'h0583);
    @(posedge mclk_in);
    #1;
    chk(alert_pin_out, 16'h0000);
    mst.wr(ACC_PTR_CTRL, 16'h8583);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(alert_pin_out, 16'h0001);
    done(12'h000);
    chk(alert_pin_out, 16'h0000);
    mst.wr(ACC_PTR_CTRL, 16'h0483);
    @(posedge mclk_in);
    conv_in <= {1'b1, 12'h000};
    @(posedge mclk_in);
    conv_in <= '0;
    @(posedge mclk_in);
    #1;
    chk(alert_pin_out, 16'h0000);
    @(posedge mclk_in);
    #1;
    chk(alert_pin_out, 16'h0001);
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_fields();
    t_start();
    t_alert();
    t_ready();
    give_verdict();
  end
endmodule
`default_nettype wire
